// ---- core/clcd_ctrl.sv ----
`timescale 1ns/1ps
`include "clcd_params.svh"
// Summary of operation
// - Instruction write when register select low; status read gives busy and counter.
// - Data write with select high stores into the RAM last addressed.
// - Data read with select high drives byte at current RAM address.
// - Entry mode bit 1 set picks increment, bit 1 cleared picks decrement.
// - Entry mode bit 0 makes each data write shift the display.
// - Display control bits 2,1,0 set display, cursor and blink enables.
// - Shift instruction bit 3 shifts display instead of cursor only.
// - Shift bit 2 set moves right, cleared moves left.
// - System set bit 4 selects 8-bit bus, cleared selects 4-bit.
// - Bit 3 gives 1/16 duty; else bit 2 picks 1/11 or 1/8.
// - Character generator address is six bits, 64 locations.
// - Display RAM address is seven bits limited to 80 locations.
// - Status bit 7 is busy; host waits for zero before instructing.
// - Unused common rows held non-select in 1/8 and 1/11 duty.
// - Display data memory holds 80 character bytes.
// - Polarity output alternates with a two-frame period.
module clcd_ctrl (
    // Clock and reset.
    input  wire logic        mclk,
    input  wire logic        rst,
    // Host bus pins.
    input  wire logic        registerSelect,
    input  wire logic        readNotWrite,
    input  wire logic        execStrobe,
    input  wire logic [7:0]  dataIn,
    output logic [7:0]       dataOut,
    output logic             dataOe,
    // Display state.
    output logic             displayOn,
    output logic             cursorOn,
    output logic             blinkOn,
    output logic [6:0]       displayShift,
    output logic [6:0]       cursorAddr,
    output logic             font5x10,
    // Panel drive.
    output logic [15:0]      comSelect,
    output logic             shiftClockOut,
    output logic             latchPulseOut,
    output logic             acPolaritySignal
);
    import clcd_pkg::*;

    logic [7:0] displayDataRam [0:`CLCD_DD_SIZE-1];
    logic [7:0] charGenRam     [0:`CLCD_CG_SIZE-1];

    logic [2:0] rsSync, rwSync, eSync;
    logic [7:0] dSync0, dSync1;
    logic       ePrev;
    logic       rsS, rwS, eS;

    logic [6:0]  addressCounter_reg, addressCounter_next;
    logic        cgSel_reg,  cgSel_next;
    logic        incr_reg,   incr_next;
    logic        shiftEn_reg, shiftEn_next;
    logic        dispOn_reg, dispOn_next;
    logic        curOn_reg,  curOn_next;
    logic        blink_reg,  blink_next;
    logic [6:0]  shift_reg,  shift_next;
    logic        busWidth8_reg, busWidth8_next;
    clcd_duty_t  duty_reg,   duty_next;
    logic        font_reg,   font_next;
    logic        nibHalf_reg, nibHalf_next;
    logic [3:0]  nibHi_reg,  nibHi_next;
    logic        busy_reg,   busy_next;
    logic [15:0] busyCnt_reg, busyCnt_next;
    clcd_state_t state_reg,  state_next;
    logic [6:0]  clrIdx_reg, clrIdx_next;
    logic [7:0]  dout_reg,   dout_next;
    logic        oe_reg,     oe_next;
    logic        readHalf_reg, readHalf_next;

    logic        fallEdge, riseEdge;
    logic        byteReady;
    logic [7:0]  byteVal;
    logic        ddWe, cgWe;
    logic [6:0]  ramAddr;
    logic [7:0]  readByte;

    function automatic logic [6:0] clcd_step(input logic [6:0] a, input logic up,
                                             input logic [6:0] lim);
        if (up)
            clcd_step = (a >= lim - 7'h01) ? 7'h00 : a + 7'h01;
        else
            clcd_step = (a == 7'h00) ? lim - 7'h01 : a - 7'h01;
    endfunction

    // Pin inputs pass two flip-flops before use.
    always_ff @(posedge mclk) begin
        if (rst) begin
            rsSync <= 3'h0;
            rwSync <= 3'h0;
            eSync  <= 3'h0;
            dSync0 <= 8'h00;
            dSync1 <= 8'h00;
            ePrev  <= 1'b0;
        end else begin
            rsSync <= {rsSync[1:0], registerSelect};
            rwSync <= {rwSync[1:0], readNotWrite};
            eSync  <= {eSync[1:0], execStrobe};
            dSync0 <= dataIn;
            dSync1 <= dSync0;
            ePrev  <= eSync[1];
        end
    end
    assign rsS      = rsSync[1];
    assign rwS      = rwSync[1];
    assign eS       = eSync[1];
    assign fallEdge = ePrev & ~eS;
    assign riseEdge = ~ePrev & eS;

    always_comb begin
        ramAddr  = cgSel_reg ? {1'b0, addressCounter_reg[5:0]} : addressCounter_reg;
        readByte = cgSel_reg ? charGenRam[addressCounter_reg[5:0]]
                             : displayDataRam[addressCounter_reg];
    end

    // Nibble assembly on the upper four lines, high nibble first.
    always_comb begin
        nibHalf_next = nibHalf_reg;
        nibHi_next   = nibHi_reg;
        byteReady    = 1'b0;
        byteVal      = dSync1;
        if (fallEdge && !rwS) begin
            if (busWidth8_reg) begin
                byteReady = 1'b1;
            end else if (!nibHalf_reg) begin
                nibHalf_next = 1'b1;
                nibHi_next   = dSync1[7:4];
            end else begin
                nibHalf_next = 1'b0;
                byteReady    = 1'b1;
                byteVal      = {nibHi_reg, dSync1[7:4]};
            end
        end
    end

    always_comb begin
        addressCounter_next = addressCounter_reg;
        cgSel_next     = cgSel_reg;
        incr_next      = incr_reg;
        shiftEn_next   = shiftEn_reg;
        dispOn_next    = dispOn_reg;
        curOn_next     = curOn_reg;
        blink_next     = blink_reg;
        shift_next     = shift_reg;
        busWidth8_next = busWidth8_reg;
        duty_next      = duty_reg;
        font_next      = font_reg;
        busy_next      = busy_reg;
        busyCnt_next   = busyCnt_reg;
        state_next     = state_reg;
        clrIdx_next    = clrIdx_reg;
        dout_next      = dout_reg;
        oe_next        = oe_reg;
        readHalf_next  = readHalf_reg;
        ddWe           = 1'b0;
        cgWe           = 1'b0;
        case (state_reg)
            CLCD_IDLE: begin
                // Data writes step the counter and optionally the display.
                if (byteReady && rsS) begin
                    ddWe = ~cgSel_reg;
                    cgWe = cgSel_reg;
                    addressCounter_next = clcd_step(addressCounter_reg, incr_reg,
                        cgSel_reg ? 7'(`CLCD_CG_SIZE) : 7'(`CLCD_DD_SIZE));
                    if (shiftEn_reg)
                        shift_next = clcd_step(shift_reg, incr_reg, 7'(`CLCD_DD_SIZE));
                end else if (byteReady && !busy_reg) begin
                    // Instruction decode; refused while busy.
                    busy_next    = 1'b1;
                    busyCnt_next = 16'(`CLCD_BUSY_CYC);
                    state_next   = CLCD_EXEC;
                    if (byteVal[7]) begin
                        cgSel_next = 1'b0;
                        addressCounter_next = (byteVal[6:0] < 7'(`CLCD_DD_SIZE))
                            ? byteVal[6:0] : 7'h00;
                    end else if (byteVal[6]) begin
                        cgSel_next = 1'b1;
                        addressCounter_next = {1'b0, byteVal[5:0]};
                    end else if (byteVal[5]) begin
                        busWidth8_next = byteVal[4];
                        font_next = ~byteVal[3] & byteVal[2];
                        duty_next = byteVal[3] ? CLCD_DUTY16
                                  : (byteVal[2] ? CLCD_DUTY11 : CLCD_DUTY8);
                    end else if (byteVal[4]) begin
                        if (byteVal[3])
                            shift_next = clcd_step(shift_reg, byteVal[2], 7'(`CLCD_DD_SIZE));
                        else
                            addressCounter_next = clcd_step(addressCounter_reg, byteVal[2],
                                7'(`CLCD_DD_SIZE));
                    end else if (byteVal[3]) begin
                        dispOn_next = byteVal[2];
                        curOn_next  = byteVal[1];
                        blink_next  = byteVal[0];
                    end else if (byteVal[2]) begin
                        incr_next    = byteVal[1];
                        shiftEn_next = byteVal[0];
                    end else if (byteVal[1]) begin
                        addressCounter_next = 7'h00;
                        shift_next = 7'h00;
                        cgSel_next = 1'b0;
                    end else if (byteVal[0]) begin
                        clrIdx_next = 7'h00;
                        addressCounter_next = 7'h00;
                        shift_next = 7'h00;
                        incr_next  = 1'b1;
                        cgSel_next = 1'b0;
                        state_next = CLCD_CLEAR;
                    end
                end
            end
            CLCD_EXEC: begin
                busyCnt_next = busyCnt_reg - 16'h0001;
                if (busyCnt_reg <= 16'h0001) begin
                    busy_next  = 1'b0;
                    state_next = CLCD_IDLE;
                end
            end
            CLCD_CLEAR: begin
                ddWe = 1'b1;
                clrIdx_next = clrIdx_reg + 7'h01;
                if (clrIdx_reg == 7'(`CLCD_DD_SIZE - 1))
                    state_next = CLCD_EXEC;
            end
            default: state_next = CLCD_IDLE;
        endcase
        // Read drive while strobe high; status or RAM byte chosen on rise.
        if (riseEdge && rwS) begin
            oe_next = 1'b1;
            if (!rsS)
                dout_next = {busy_reg, addressCounter_reg};
            else
                dout_next = readByte;
            if (!busWidth8_reg && readHalf_reg)
                dout_next = {dout_reg[3:0], 4'h0};
        end else if (fallEdge && rwS) begin
            oe_next = 1'b0;
            if (!busWidth8_reg)
                readHalf_next = ~readHalf_reg;
            if (rsS && (busWidth8_reg || readHalf_reg))
                addressCounter_next = clcd_step(addressCounter_reg, incr_reg,
                    cgSel_reg ? 7'(`CLCD_CG_SIZE) : 7'(`CLCD_DD_SIZE));
        end else if (!eS) begin
            oe_next = 1'b0;
        end
    end

    // RAM writes are captured from the strobe fall, or fill blanks during clear.
    always_ff @(posedge mclk) begin
        if (ddWe)
            displayDataRam[state_reg == CLCD_CLEAR ? clrIdx_reg : ramAddr]
                <= (state_reg == CLCD_CLEAR) ? `CLCD_BLANK : byteVal;
        if (cgWe)
            charGenRam[ramAddr[5:0]] <= byteVal;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            addressCounter_reg <= 7'h00;
            cgSel_reg     <= 1'b0;
            incr_reg      <= 1'b1;
            shiftEn_reg   <= 1'b0;
            dispOn_reg    <= 1'b0;
            curOn_reg     <= 1'b0;
            blink_reg     <= 1'b0;
            shift_reg     <= 7'h00;
            busWidth8_reg <= 1'b1;
            duty_reg      <= CLCD_DUTY8;
            font_reg      <= 1'b0;
            nibHalf_reg   <= 1'b0;
            nibHi_reg     <= 4'h0;
            busy_reg      <= 1'b0;
            busyCnt_reg   <= 16'h0000;
            state_reg     <= CLCD_IDLE;
            clrIdx_reg    <= 7'h00;
            dout_reg      <= 8'h00;
            oe_reg        <= 1'b0;
            readHalf_reg  <= 1'b0;
        end else begin
            addressCounter_reg <= addressCounter_next;
            cgSel_reg     <= cgSel_next;
            incr_reg      <= incr_next;
            shiftEn_reg   <= shiftEn_next;
            dispOn_reg    <= dispOn_next;
            curOn_reg     <= curOn_next;
            blink_reg     <= blink_next;
            shift_reg     <= shift_next;
            busWidth8_reg <= busWidth8_next;
            duty_reg      <= duty_next;
            font_reg      <= font_next;
            nibHalf_reg   <= nibHalf_next;
            nibHi_reg     <= nibHi_next;
            busy_reg      <= busy_next;
            busyCnt_reg   <= busyCnt_next;
            state_reg     <= state_next;
            clrIdx_reg    <= clrIdx_next;
            dout_reg      <= dout_next;
            oe_reg        <= oe_next;
            readHalf_reg  <= readHalf_next;
        end
    end

    assign dataOut      = dout_reg;
    assign dataOe       = oe_reg;
    assign displayOn    = dispOn_reg;
    assign cursorOn     = curOn_reg;
    assign blinkOn      = blink_reg;
    assign displayShift = shift_reg;
    assign cursorAddr   = addressCounter_reg;
    assign font5x10     = font_reg;

    clcd_scan scanUnit (
        .mclk             (mclk),
        .rst              (rst),
        .duty             (duty_reg),
        .comSelect        (comSelect),
        .shiftClockOut    (shiftClockOut),
        .latchPulseOut    (latchPulseOut),
        .acPolaritySignal (acPolaritySignal)
    );
endmodule

// ---- core/clcd_params.svh ----
`ifndef CLCD_PARAMS_SVH
`define CLCD_PARAMS_SVH
`define CLCD_DD_SIZE      80
`define CLCD_CG_SIZE      64
`define CLCD_BLANK        8'h20
`define CLCD_BUSY_BIT     7
`define CLCD_BUSY_NS      40000
`define CLCD_CLK_NS       100
`define CLCD_BUSY_CYC     ((`CLCD_BUSY_NS + `CLCD_CLK_NS - 1) / `CLCD_CLK_NS)
`define CLCD_SCAN_DIV     8'h3F
`define CLCD_LP_WIDTH     8'h04
`define CLCD_COM_COUNT    16
`endif

// ---- core/clcd_pkg.sv ----
package clcd_pkg;
    typedef enum logic [1:0] {
        CLCD_DUTY8  = 2'h0,
        CLCD_DUTY11 = 2'h1,
        CLCD_DUTY16 = 2'h2
    } clcd_duty_t;
    typedef enum logic [1:0] {
        CLCD_IDLE  = 2'h0,
        CLCD_EXEC  = 2'h1,
        CLCD_CLEAR = 2'h2
    } clcd_state_t;
endpackage

// ---- core/clcd_scan.sv ----
`timescale 1ns/1ps
`include "clcd_params.svh"
module clcd_scan (
    // Clock and reset.
    input  wire logic              mclk,
    input  wire logic              rst,
    // Configuration.
    input  wire clcd_pkg::clcd_duty_t duty,
    // Drive outputs.
    output logic [15:0]            comSelect,
    output logic                   shiftClockOut,
    output logic                   latchPulseOut,
    output logic                   acPolaritySignal
);
    import clcd_pkg::*;

    logic [7:0]  divReg,   divNext;
    logic [3:0]  rowReg,   rowNext;
    logic        frameReg, frameNext;
    logic        polReg,   polNext;
    logic        sclReg,   sclNext;
    logic        lpReg,    lpNext;
    logic [15:0] comReg,   comNext;
    logic [3:0]  lastRow;

    always_comb begin
        case (duty)
            CLCD_DUTY8:  lastRow = 4'h7;
            CLCD_DUTY11: lastRow = 4'hA;
            default:     lastRow = 4'hF;
        endcase
        divNext   = divReg + 8'h01;
        rowNext   = rowReg;
        frameNext = frameReg;
        polNext   = polReg;
        if (divReg == `CLCD_SCAN_DIV) begin
            divNext = 8'h00;
            if (rowReg >= lastRow) begin
                rowNext   = 4'h0;
                frameNext = ~frameReg;
                // Polarity flips every frame, giving a two-frame period.
                polNext   = ~polReg;
            end else begin
                rowNext = rowReg + 4'h1;
            end
        end
        sclNext = divReg[0];
        lpNext  = (divReg < `CLCD_LP_WIDTH);
        // Rows past the last duty row stay at non-select.
        comNext = (rowReg <= lastRow) ? (16'h0001 << rowReg) : 16'h0000;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            divReg   <= 8'h00;
            rowReg   <= 4'h0;
            frameReg <= 1'b0;
            polReg   <= 1'b0;
            sclReg   <= 1'b0;
            lpReg    <= 1'b0;
            comReg   <= 16'h0000;
        end else begin
            divReg   <= divNext;
            rowReg   <= rowNext;
            frameReg <= frameNext;
            polReg   <= polNext;
            sclReg   <= sclNext;
            lpReg    <= lpNext;
            comReg   <= comNext;
        end
    end

    assign comSelect        = comReg;
    assign shiftClockOut    = sclReg;
    assign latchPulseOut    = lpReg;
    assign acPolaritySignal = polReg;
endmodule

// ---- sim/clcd_ctrl_props.sv ----
`timescale 1ns/1ps
module clcd_ctrl_props (
    // Clock and reset.
    input wire logic        mclk,
    input wire logic        rst,
    // Host bus pins.
    input wire logic        registerSelect,
    input wire logic        readNotWrite,
    input wire logic        execStrobe,
    input wire logic [7:0]  dataIn,
    input wire logic [7:0]  dataOut,
    input wire logic        dataOe,
    // Display state.
    input wire logic        displayOn,
    input wire logic        cursorOn,
    input wire logic        blinkOn,
    input wire logic [6:0]  displayShift,
    input wire logic [6:0]  cursorAddr,
    input wire logic        font5x10,
    // Panel drive.
    input wire logic [15:0] comSelect,
    input wire logic        shiftClockOut,
    input wire logic        latchPulseOut,
    input wire logic        acPolaritySignal
);
    import clcd_pkg::*;
    logic        strobeReg, strobeNext, frReg, frNext;
    logic [10:0] accAgeReg, accAgeNext, cmdAgeReg, cmdAgeNext, frAgeReg, frAgeNext;

    // Ages saturate so that a long idle stretch never wraps back into range.
    always_comb begin
        strobeNext = execStrobe;
        frNext     = acPolaritySignal;
        accAgeNext = accAgeReg + {10'h000, ~&accAgeReg};
        cmdAgeNext = cmdAgeReg + {10'h000, ~&cmdAgeReg};
        frAgeNext  = (frReg != acPolaritySignal) ? 11'h000 : frAgeReg + {10'h000, ~&frAgeReg};
        if (strobeReg && !execStrobe) begin
            accAgeNext = 11'h000;
            if (!registerSelect && !readNotWrite) begin
                cmdAgeNext = 11'h000;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            strobeReg <= 1'b0;
            frReg     <= 1'b0;
            accAgeReg <= 11'h000;
            cmdAgeReg <= 11'h000;
            frAgeReg  <= 11'h000;
        end else begin
            strobeReg <= strobeNext;
            frReg     <= frNext;
            accAgeReg <= accAgeNext;
            cmdAgeReg <= cmdAgeNext;
            frAgeReg  <= frAgeNext;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    property p_oe_rise;
        $rose(dataOe) |-> $past(execStrobe, 2) && $past(readNotWrite, 2);
    endproperty
    a_oe_rise: assert property (p_oe_rise) else $error("bus driven without read");
    property p_oe_release;
        $fell(execStrobe) |-> ##[3:6] !dataOe;
    endproperty
    a_oe_release: assert property (p_oe_release) else $error("bus held too long");
    property p_no_oe_write;
        (!readNotWrite) [*7] |-> !dataOe;
    endproperty
    a_no_oe_write: assert property (p_no_oe_write) else $error("bus driven in write");
    property p_com_onehot;
        $onehot0(comSelect);
    endproperty
    a_com_onehot: assert property (p_com_onehot) else $error("two rows selected");
    property p_fr_min;
        $changed(acPolaritySignal) |-> frAgeReg >= 11'h020;
    endproperty
    a_fr_min: assert property (p_fr_min) else $error("polarity toggled early");
    property p_fr_max;
        frAgeReg <= 11'h44C;
    endproperty
    a_fr_max: assert property (p_fr_max) else $error("polarity stuck");
    property p_flags_cause;
        !$past(rst) && ($changed(displayOn) || $changed(cursorOn) || $changed(blinkOn))
            |-> cmdAgeReg <= 11'h00A;
    endproperty
    a_flags_cause: assert property (p_flags_cause) else $error("switch moved alone");
    property p_cursor_cause;
        !$past(rst) && $changed(cursorAddr) |-> accAgeReg <= 11'h1F4;
    endproperty
    a_cursor_cause: assert property (p_cursor_cause) else $error("counter moved alone");
    property p_cursor_range;
        cursorAddr <= 7'h4F;
    endproperty
    a_cursor_range: assert property (p_cursor_range) else $error("counter past end");
    property p_shift_range;
        displayShift <= 7'h4F;
    endproperty
    a_shift_range: assert property (p_shift_range) else $error("shift past end");
    c_read: cover property ($rose(dataOe));
    c_polarity: cover property ($changed(acPolaritySignal));
    c_switch: cover property ($rose(displayOn));
endmodule

bind clcd_ctrl clcd_ctrl_props u_clcd_ctrl_props (.mclk(mclk), .rst(rst),
    .registerSelect(registerSelect), .readNotWrite(readNotWrite), .execStrobe(execStrobe),
    .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .displayOn(displayOn),
    .cursorOn(cursorOn), .blinkOn(blinkOn), .displayShift(displayShift),
    .cursorAddr(cursorAddr), .font5x10(font5x10), .comSelect(comSelect),
    .shiftClockOut(shiftClockOut), .latchPulseOut(latchPulseOut),
    .acPolaritySignal(acPolaritySignal));

// ---- sim/clcd_host_model.sv ----
`timescale 1ns/1ps
module clcd_host_model (
    // Clock.
    input wire logic        mclk,
    // Host bus pins.
    output logic            registerSelect,
    output logic            readNotWrite,
    output logic            execStrobe,
    output logic [7:0]      dataIn,
    input wire logic [7:0]  dataOut,
    input wire logic        dataOe
);
    logic nibbleMode;

    initial begin
        registerSelect = 1'b0;
        readNotWrite = 1'b0;
        execStrobe = 1'b0;
        dataIn = 8'hA5;
        nibbleMode = 1'b0;
    end

    // Controls and data are set with the rise and stay put until well after the fall.
    task automatic pulse(input logic rs, input logic rw, input logic [7:0] d,
                         output logic [7:0] q);
        @(negedge mclk);
        registerSelect = rs;
        readNotWrite = rw;
        dataIn = d;
        execStrobe = 1'b1;
        repeat (6) @(negedge mclk);
        q = (dataOe === 1'b1) ? dataOut : 8'hXX;
        execStrobe = 1'b0;
        repeat (6) @(negedge mclk);
        dataIn = ~d;
    endtask

    task automatic xfer(input logic rs, input logic rw, input logic [7:0] d,
                        output logic [7:0] q);
        logic [7:0] hi;
        logic [7:0] lo;
        if (nibbleMode) begin
            pulse(rs, rw, {d[7:4], ~d[3:0]}, hi);
            pulse(rs, rw, {d[3:0], ~d[7:4]}, lo);
            q = {hi[7:4], lo[7:4]};
        end else begin
            pulse(rs, rw, d, q);
        end
    endtask
endmodule

// ---- sim/char_lcd_controller_cmd_if_test.sv ----
`timescale 1ns/1ps
module char_lcd_controller_cmd_if_test;
    import clcd_pkg::*;
    logic        mclk, rst, registerSelect, readNotWrite, execStrobe, dataOe;
    logic        displayOn, cursorOn, blinkOn, font5x10;
    logic        shiftClockOut, latchPulseOut, acPolaritySignal;
    logic [7:0]  dataIn, dataOut, s;
    logic [6:0]  displayShift, cursorAddr, s0;
    logic [15:0] comSelect, seen;
    int          errCount, totalChecks, ac, dd[80], cg[64], sc, lp;
    bit          inc, cgSel;
    logic [7:0]  dutyCmd[3] = '{8'h30, 8'h34, 8'h38};
    logic        fontExp[3] = '{1'b0, 1'b1, 1'b0};
    logic [15:0] rowsExp[3] = '{16'h00FF, 16'h07FF, 16'hFFFF};

    initial mclk = 1'b0;
    always #50 mclk = ~mclk;

    clcd_ctrl u_clcd_ctrl (.mclk(mclk), .rst(rst), .registerSelect(registerSelect),
        .readNotWrite(readNotWrite), .execStrobe(execStrobe), .dataIn(dataIn),
        .dataOut(dataOut), .dataOe(dataOe), .displayOn(displayOn), .cursorOn(cursorOn),
        .blinkOn(blinkOn), .displayShift(displayShift), .cursorAddr(cursorAddr),
        .font5x10(font5x10), .comSelect(comSelect), .shiftClockOut(shiftClockOut),
        .latchPulseOut(latchPulseOut), .acPolaritySignal(acPolaritySignal));
    clcd_host_model u_clcd_host_model (.mclk(mclk), .registerSelect(registerSelect),
        .readNotWrite(readNotWrite), .execStrobe(execStrobe), .dataIn(dataIn),
        .dataOut(dataOut), .dataOe(dataOe));

    task automatic chk(input logic ok, input string what);
        totalChecks++;
        if (ok !== 1'b1) begin
            errCount++;
            $display("[FAIL] %0t ns %s", $time, what);
        end
    endtask

    task automatic finalReport;
        $display("checks %0d mismatches %0d", totalChecks, errCount);
        if (errCount == 0 && totalChecks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    function automatic void step;
        int lim;
        lim = cgSel ? 64 : 80;
        ac = inc ? (ac + 1) % lim : (ac + lim - 1) % lim;
    endfunction

    // The host may only go on once the status byte reads idle.
    task automatic poll(input bit wasCmd);
        int n;
        n = 0;
        u_clcd_host_model.xfer(1'b0, 1'b1, 8'h00, s);
        if (wasCmd) chk(s[7], "busy missing");
        while (s[7] !== 1'b0 && n < 200) begin
            u_clcd_host_model.xfer(1'b0, 1'b1, 8'h00, s);
            n++;
        end
        chk(s === {1'b0, 7'(ac)}, "status byte");
        if (!cgSel) chk(cursorAddr === 7'(ac), "address counter");
    endtask

    task automatic cmd(input logic [7:0] v);
        u_clcd_host_model.xfer(1'b0, 1'b0, v, s);
        if (v == 8'h01) begin
            foreach (dd[i]) dd[i] = 32'h20;
            inc = 1;
            ac = 0;
            cgSel = 0;
        end else if (v[7:1] == 7'h01) begin
            ac = 0;
            cgSel = 0;
        end else if (v[7:2] == 6'h01) begin
            inc = v[1];
        end else if (v[7:4] == 4'h1 && !v[3]) begin
            ac = (ac + (v[2] ? 1 : 79)) % 80;
        end else if (v[7:6] == 2'h1) begin
            ac = v[5:0];
            cgSel = 1;
        end else if (v[7]) begin
            ac = (v[6:0] < 80) ? v[6:0] : 0;
            cgSel = 0;
        end
        poll(1'b1);
    endtask

    task automatic wr(input logic [7:0] d);
        u_clcd_host_model.xfer(1'b1, 1'b0, d, s);
        if (cgSel) cg[ac] = d; else dd[ac] = d;
        step();
        poll(1'b0);
    endtask

    task automatic rd;
        u_clcd_host_model.xfer(1'b1, 1'b1, 8'h00, s);
        chk(s === 8'(cgSel ? cg[ac] : dd[ac]), "read data");
        step();
        poll(1'b0);
    endtask

    initial begin
        void'($urandom(32'hA666F14A));
        rst = 1'b1;
        errCount = 0;
        totalChecks = 0;
        ac = 0;
        inc = 1;
        cgSel = 0;
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        rst = 1'b0;
        @(negedge mclk);
        chk(!displayOn && !dataOe && cursorAddr === 7'h00, "reset state");
        for (int v = 0; v < 8; v++) begin
            cmd(8'h08 | 8'(v));
            chk({displayOn, cursorOn, blinkOn} === 3'(v), "display switches");
        end
        u_clcd_host_model.xfer(1'b0, 1'b0, 8'h0B, s);
        u_clcd_host_model.xfer(1'b0, 1'b0, 8'h08, s);
        poll(1'b1);
        chk({displayOn, cursorOn, blinkOn} === 3'h3, "refusal while busy");
        $display("display control test done");
        cmd(8'h01);
        cmd(8'hCD);
        repeat (4) wr(8'($urandom));
        cmd(8'hCD);
        repeat (4) rd();
        cmd(8'h85);
        rd();
        cmd(8'h04);
        cmd(8'h80);
        wr(8'($urandom));
        cmd(8'hD0);
        cmd(8'h06);
        $display("display memory test done");
        cmd(8'h7F);
        repeat (2) wr(8'($urandom) & 8'h1F);
        cmd(8'h7F);
        repeat (2) rd();
        $display("glyph memory test done");
        cmd(8'h8A);
        cmd(8'h14);
        cmd(8'h10);
        s0 = displayShift;
        cmd(8'h1C);
        chk(displayShift !== s0, "display shift right");
        cmd(8'h18);
        chk(displayShift === s0, "display shift left");
        cmd(8'h07);
        wr(8'h41);
        chk(displayShift !== s0, "entry shift");
        cmd(8'h06);
        s0 = displayShift;
        wr(8'h42);
        chk(displayShift === s0, "entry no shift");
        cmd(8'h02);
        chk(displayShift === 7'h00, "return home");
        $display("shift test done");
        foreach (dutyCmd[i]) begin
            cmd(dutyCmd[i]);
            repeat (1100) @(negedge mclk);
            seen = 16'h0000;
            sc = 0;
            lp = 0;
            repeat (1100) begin
                @(negedge mclk);
                seen = seen | comSelect;
                sc += shiftClockOut;
                lp += latchPulseOut;
            end
            chk(sc == 550, "shift clock");
            chk(lp >= 68 && lp <= 72, "latch pulse");
            chk(font5x10 === fontExp[i], "font select");
            chk(seen === rowsExp[i], "common rows");
        end
        $display("duty test done");
        u_clcd_host_model.xfer(1'b0, 1'b0, 8'h20, s);
        u_clcd_host_model.nibbleMode = 1'b1;
        poll(1'b1);
        cmd(8'hA8);
        wr(8'($urandom));
        cmd(8'hA8);
        rd();
        $display("nibble bus test done");
        finalReport();
    end

    initial begin
        repeat (100000) @(posedge mclk);
        errCount++;
        $display("[FAIL] %0t ns watchdog expired", $time);
        finalReport();
    end
endmodule
